// *** core/ppc_fault_enc.sv ***
// Maps a stage violation onto its exception code
module ppc_fault_enc (
    // Clock and reset, for checks only
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    // Stage results
    input  wire logic                  seg_stage,
    input  wire ppc_pkg::ppc_seg_res_s seg_res,
    input  wire logic                  page_viol,
    // Exception code
    output ppc_pkg::ppc_exc_e          code
);

    always_comb begin
        code = ppc_pkg::PPC_EXC_NONE;
        if (seg_stage) begin
            // Stack fault wins when both segment faults are flagged
            if (seg_res.stack_viol) begin
                code = ppc_pkg::PPC_EXC_STACK_FAULT; // RL4
            end else if (seg_res.prot_viol) begin
                code = ppc_pkg::PPC_EXC_GENERAL_PROTECTION_FAULT; // RL4
            end
        end else if (page_viol) begin
            code = ppc_pkg::PPC_EXC_PAGE_FAULT; // RL5
        end
    end

    chk_seg_not_pf: assert property ( // RL4
        @(posedge ref_clk) disable iff (!arst_n)
        seg_stage |-> code != ppc_pkg::PPC_EXC_PAGE_FAULT)
        else $error("segment stage produced a page fault code");

endmodule

// *** core/ppc_map.svh ***
// Constants for the privilege and protection checker
// Contract
// RL1 - Segment checks finish before page checks start, never reversed or overlapped
// RL2 - A segment violation skips the page check for that access
// RL3 - Any violation raises an exception and no memory access happens
// RL4 - Segment violations report general protection or stack fault, never page fault
// RL5 - Page violations report page fault
// RL6 - Control, debug register moves, table and task loads, model register reads need level 0
// RL7 - Cache invalidate and both tlb invalidates need level 0
// RL8 - Global interrupt flag clear needs level 0
// RL9 - Task switched flag clear and halt need level 0
// RL10 - Secure attested init needs level 0
// RL11 - Irq clear, watch setup/wait, counter and timestamp reads use os configured level
// RL12 - Requestor adjust, access rights load, segment limit load run at any level
// RL13 - Interrupt returns and debug breakpoint trap run at any level
// RL14 - Management mode return has no privilege restriction
// RL15 - Segment base reads and descriptor table stores run at any level
// RL16 - Level 0 instruction at nonzero level is suppressed with general protection fault
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

`define PPC_LEVEL_SUPER    2'h0
`define PPC_OS_BITS        6
`define PPC_OSB_IRQ_CLEAR  3'h0
`define PPC_OSB_WATCH_SET  3'h1
`define PPC_OSB_WATCH_WAIT 3'h2
`define PPC_OSB_PERF_READ  3'h3
`define PPC_OSB_TS_READ    3'h4
`define PPC_OSB_TSCPU_READ 3'h5
`define PPC_OSB_NONE       3'h0

`endif

// *** core/ppc_pkg.sv ***
// Types shared by the privilege and protection checker
package ppc_pkg;

    typedef enum logic [4:0] {
        PPC_OP_REQUESTOR_LEVEL_ADJUST = 5'b00000,
        PPC_OP_GLOBAL_IRQ_FLAG_CLEAR  = 5'b00001,
        PPC_OP_IRQ_FLAG_CLEAR         = 5'b00010,
        PPC_OP_TASK_SWITCHED_CLEAR    = 5'b00011,
        PPC_OP_HALT_INSTRUCTION       = 5'b00100,
        PPC_OP_DEBUG_BREAKPOINT_TRAP  = 5'b00101,
        PPC_OP_CACHE_INVALIDATE       = 5'b00110,
        PPC_OP_TLB_ENTRY_INVALIDATE   = 5'b00111,
        PPC_OP_TAGGED_TLB_INVALIDATE  = 5'b01000,
        PPC_OP_INTERRUPT_RETURN       = 5'b01001,
        PPC_OP_ACCESS_RIGHTS_LOAD     = 5'b01010,
        PPC_OP_GLOBAL_TABLE_LOAD      = 5'b01011,
        PPC_OP_INTERRUPT_TABLE_LOAD   = 5'b01100,
        PPC_OP_LOCAL_TABLE_LOAD       = 5'b01101,
        PPC_OP_STATUS_WORD_LOAD       = 5'b01110,
        PPC_OP_SEGMENT_LIMIT_LOAD     = 5'b01111,
        PPC_OP_TASK_REG_LOAD          = 5'b10000,
        PPC_OP_WATCH_SETUP            = 5'b10001,
        PPC_OP_CONTROL_REG_MOVE       = 5'b10010,
        PPC_OP_DEBUG_REG_MOVE         = 5'b10011,
        PPC_OP_WATCH_WAIT             = 5'b10100,
        PPC_OP_F_SEGMENT_BASE_READ    = 5'b10101,
        PPC_OP_G_SEGMENT_BASE_READ    = 5'b10110,
        PPC_OP_MODEL_SPECIFIC_READ    = 5'b10111,
        PPC_OP_PERF_COUNTER_READ      = 5'b11000,
        PPC_OP_TIMESTAMP_READ         = 5'b11001,
        PPC_OP_TIMESTAMP_CPU_ID_READ  = 5'b11010,
        PPC_OP_MANAGEMENT_MODE_RETURN = 5'b11011,
        PPC_OP_GLOBAL_TABLE_STORE     = 5'b11100,
        PPC_OP_INTERRUPT_TABLE_STORE  = 5'b11101,
        PPC_OP_SECURE_ATTESTED_INIT   = 5'b11110,
        PPC_OP_LOCAL_TABLE_STORE      = 5'b11111
    } ppc_op_e;

    typedef enum logic [1:0] {
        PPC_CLS_PRIV0 = 2'b00,
        PPC_CLS_OSCTL = 2'b01,
        PPC_CLS_ANY   = 2'b10
    } ppc_class_e;

    typedef enum logic [1:0] {
        PPC_EXC_NONE                     = 2'b00,
        PPC_EXC_GENERAL_PROTECTION_FAULT = 2'b01,
        PPC_EXC_STACK_FAULT              = 2'b10,
        PPC_EXC_PAGE_FAULT               = 2'b11
    } ppc_exc_e;

    typedef enum logic [1:0] {
        PPC_ST_IDLE = 2'b00,
        PPC_ST_SEG  = 2'b01,
        PPC_ST_PAGE = 2'b10
    } ppc_acc_st_e;

    typedef struct packed {
        ppc_op_e    op;
        logic [1:0] current_privilege_level;
    } ppc_instr_s;

    typedef struct packed {
        logic prot_viol;
        logic stack_viol;
    } ppc_seg_res_s;

    typedef struct packed {
        logic     valid;
        ppc_exc_e code;
    } ppc_fault_s;

endpackage

// *** core/ppc_priv_decode.sv ***
// Privilege class lookup for system-management instructions
`include "ppc_map.svh"

module ppc_priv_decode (
    // Instruction
    input  wire ppc_pkg::ppc_op_e    op,
    // Class and os configuration bit
    output ppc_pkg::ppc_class_e      cls,
    output logic [2:0]               os_idx
);

    always_comb begin
        os_idx = `PPC_OSB_NONE;
        cls    = ppc_pkg::PPC_CLS_ANY;
        unique case (op)
            ppc_pkg::PPC_OP_CONTROL_REG_MOVE, ppc_pkg::PPC_OP_DEBUG_REG_MOVE,
            ppc_pkg::PPC_OP_GLOBAL_TABLE_LOAD, ppc_pkg::PPC_OP_INTERRUPT_TABLE_LOAD,
            ppc_pkg::PPC_OP_LOCAL_TABLE_LOAD, ppc_pkg::PPC_OP_TASK_REG_LOAD,
            ppc_pkg::PPC_OP_STATUS_WORD_LOAD,
            ppc_pkg::PPC_OP_MODEL_SPECIFIC_READ: cls = ppc_pkg::PPC_CLS_PRIV0; // RL6
            ppc_pkg::PPC_OP_CACHE_INVALIDATE, ppc_pkg::PPC_OP_TLB_ENTRY_INVALIDATE,
            ppc_pkg::PPC_OP_TAGGED_TLB_INVALIDATE: cls = ppc_pkg::PPC_CLS_PRIV0; // RL7
            ppc_pkg::PPC_OP_GLOBAL_IRQ_FLAG_CLEAR: cls = ppc_pkg::PPC_CLS_PRIV0; // RL8
            ppc_pkg::PPC_OP_TASK_SWITCHED_CLEAR,
            ppc_pkg::PPC_OP_HALT_INSTRUCTION: cls = ppc_pkg::PPC_CLS_PRIV0; // RL9
            ppc_pkg::PPC_OP_SECURE_ATTESTED_INIT: cls = ppc_pkg::PPC_CLS_PRIV0; // RL10
            ppc_pkg::PPC_OP_IRQ_FLAG_CLEAR: begin
                cls    = ppc_pkg::PPC_CLS_OSCTL; // RL11
                os_idx = `PPC_OSB_IRQ_CLEAR;
            end
            ppc_pkg::PPC_OP_WATCH_SETUP: begin
                cls    = ppc_pkg::PPC_CLS_OSCTL; // RL11
                os_idx = `PPC_OSB_WATCH_SET;
            end
            ppc_pkg::PPC_OP_WATCH_WAIT: begin
                cls    = ppc_pkg::PPC_CLS_OSCTL; // RL11
                os_idx = `PPC_OSB_WATCH_WAIT;
            end
            ppc_pkg::PPC_OP_PERF_COUNTER_READ: begin
                cls    = ppc_pkg::PPC_CLS_OSCTL; // RL11
                os_idx = `PPC_OSB_PERF_READ;
            end
            ppc_pkg::PPC_OP_TIMESTAMP_READ: begin
                cls    = ppc_pkg::PPC_CLS_OSCTL; // RL11
                os_idx = `PPC_OSB_TS_READ;
            end
            ppc_pkg::PPC_OP_TIMESTAMP_CPU_ID_READ: begin
                cls    = ppc_pkg::PPC_CLS_OSCTL; // RL11
                os_idx = `PPC_OSB_TSCPU_READ;
            end
            ppc_pkg::PPC_OP_REQUESTOR_LEVEL_ADJUST, ppc_pkg::PPC_OP_ACCESS_RIGHTS_LOAD,
            ppc_pkg::PPC_OP_SEGMENT_LIMIT_LOAD: cls = ppc_pkg::PPC_CLS_ANY; // RL12
            ppc_pkg::PPC_OP_INTERRUPT_RETURN,
            ppc_pkg::PPC_OP_DEBUG_BREAKPOINT_TRAP: cls = ppc_pkg::PPC_CLS_ANY; // RL13
            ppc_pkg::PPC_OP_MANAGEMENT_MODE_RETURN: cls = ppc_pkg::PPC_CLS_ANY; // RL14
            ppc_pkg::PPC_OP_F_SEGMENT_BASE_READ, ppc_pkg::PPC_OP_G_SEGMENT_BASE_READ,
            ppc_pkg::PPC_OP_GLOBAL_TABLE_STORE, ppc_pkg::PPC_OP_INTERRUPT_TABLE_STORE,
            ppc_pkg::PPC_OP_LOCAL_TABLE_STORE: cls = ppc_pkg::PPC_CLS_ANY; // RL15
        endcase
    end

endmodule

// *** core/ppc_protect_check.sv ***
// Privilege gate for system instructions and ordered segment then page access checks
`include "ppc_map.svh"

module ppc_protect_check (
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       arst_n,
    // Instruction privilege request
    input  wire logic                       instr_valid,
    input  wire ppc_pkg::ppc_instr_s        instr,
    input  wire logic [`PPC_OS_BITS-1:0]    os_user_allow,
    // Instruction verdict
    output logic                            instr_exec,
    output logic                            instr_fault,
    output ppc_pkg::ppc_exc_e               instr_fault_code,
    // Access request
    input  wire logic                       acc_valid,
    output logic                            acc_ready,
    // Segment stage
    output logic                            seg_chk_req,
    input  wire logic                       seg_chk_done,
    input  wire ppc_pkg::ppc_seg_res_s      seg_res,
    // Page stage
    output logic                            page_chk_req,
    input  wire logic                       page_chk_done,
    input  wire logic                       page_viol,
    // Access outcome
    output logic                            mem_req,
    output ppc_pkg::ppc_fault_s             acc_fault
);

    ppc_pkg::ppc_class_e   cls;
    logic [2:0]            os_idx;
    logic                  allowed;
    logic                  is_super;
    ppc_pkg::ppc_acc_st_e  state_r;
    ppc_pkg::ppc_acc_st_e  state_nxt;
    ppc_pkg::ppc_exc_e     stage_code;
    logic                  seg_bad;
    logic                  instr_exec_r;
    logic                  instr_fault_r;
    ppc_pkg::ppc_exc_e     instr_code_r;
    logic                  mem_req_r;
    ppc_pkg::ppc_fault_s   acc_fault_r;

    // Instruction privilege gate

    ppc_priv_decode u_decode (
        .op     (instr.op),
        .cls    (cls),
        .os_idx (os_idx)
    );

    assign is_super = instr.current_privilege_level == `PPC_LEVEL_SUPER;

    always_comb begin
        allowed = 1'b0;
        unique case (cls)
            ppc_pkg::PPC_CLS_PRIV0: allowed = is_super; // RL6
            // Os configuration opens the instruction to every level
            ppc_pkg::PPC_CLS_OSCTL: allowed = is_super || os_user_allow[os_idx]; // RL11
            ppc_pkg::PPC_CLS_ANY:   allowed = 1'b1; // RL13
            default:                allowed = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            instr_exec_r  <= 1'b0;
            instr_fault_r <= 1'b0;
            instr_code_r  <= ppc_pkg::PPC_EXC_NONE;
        end else begin
            instr_exec_r  <= instr_valid && allowed;
            // Suppressed, never executed, when the level is too low
            instr_fault_r <= instr_valid && !allowed; // RL16
            instr_code_r  <= (instr_valid && !allowed) ?
                             ppc_pkg::PPC_EXC_GENERAL_PROTECTION_FAULT :
                             ppc_pkg::PPC_EXC_NONE; // RL16
        end
    end

    assign instr_exec       = instr_exec_r;
    assign instr_fault      = instr_fault_r;
    assign instr_fault_code = instr_code_r;

    // Access check sequencer

    ppc_fault_enc u_enc (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .seg_stage (state_r == ppc_pkg::PPC_ST_SEG),
        .seg_res   (seg_res),
        .page_viol (page_viol),
        .code      (stage_code)
    );

    assign seg_bad = seg_res.prot_viol || seg_res.stack_viol;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ppc_pkg::PPC_ST_IDLE: begin
                if (acc_valid) begin
                    state_nxt = ppc_pkg::PPC_ST_SEG;
                end
            end
            ppc_pkg::PPC_ST_SEG: begin
                // Page stage only after the segment stage has finished clean
                if (seg_chk_done) begin
                    state_nxt = seg_bad ? ppc_pkg::PPC_ST_IDLE :
                                ppc_pkg::PPC_ST_PAGE; // RL1 RL2
                end
            end
            ppc_pkg::PPC_ST_PAGE: begin
                if (page_chk_done) begin
                    state_nxt = ppc_pkg::PPC_ST_IDLE;
                end
            end
            default: state_nxt = ppc_pkg::PPC_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ppc_pkg::PPC_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_req_r <= 1'b0;
        end else begin
            // Memory is touched only after both stages pass
            mem_req_r <= state_r == ppc_pkg::PPC_ST_PAGE && page_chk_done
                         && !page_viol; // RL3
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_fault_r <= '{valid: 1'b0, code: ppc_pkg::PPC_EXC_NONE};
        end else if ((state_r == ppc_pkg::PPC_ST_SEG && seg_chk_done && seg_bad) ||
                     (state_r == ppc_pkg::PPC_ST_PAGE && page_chk_done && page_viol)) begin
            acc_fault_r <= '{valid: 1'b1, code: stage_code}; // RL3 RL4 RL5
        end else begin
            acc_fault_r <= '{valid: 1'b0, code: ppc_pkg::PPC_EXC_NONE};
        end
    end

    // Ready only in idle, so a second access cannot overlap a running check
    assign acc_ready    = state_r == ppc_pkg::PPC_ST_IDLE;
    assign seg_chk_req  = state_r == ppc_pkg::PPC_ST_SEG;
    assign page_chk_req = state_r == ppc_pkg::PPC_ST_PAGE; // RL1
    assign mem_req      = mem_req_r;
    assign acc_fault    = acc_fault_r;

    // Checks

    chk_stage_no_overlap: assert property ( // RL1
        @(posedge ref_clk) disable iff (!arst_n)
        !(seg_chk_req && page_chk_req))
        else $error("segment and page checks overlap");

    chk_page_after_seg: assert property ( // RL1
        @(posedge ref_clk) disable iff (!arst_n)
        $rose(page_chk_req) |-> $past(seg_chk_req && seg_chk_done && !seg_bad))
        else $error("page check started without a clean segment check");

    chk_seg_skip_page: assert property ( // RL2
        @(posedge ref_clk) disable iff (!arst_n)
        (seg_chk_req && seg_chk_done && seg_bad) |=> !page_chk_req && acc_fault.valid)
        else $error("page check ran after a segment violation");

    chk_fault_no_mem: assert property ( // RL3
        @(posedge ref_clk) disable iff (!arst_n)
        (page_chk_req && page_chk_done && page_viol) |=> acc_fault.valid && !mem_req)
        else $error("memory access issued despite a page violation");

    chk_mem_needs_stages: assert property ( // RL3
        @(posedge ref_clk) disable iff (!arst_n)
        mem_req |-> $past(page_chk_req && page_chk_done && !page_viol))
        else $error("memory access without a passed page check");

    chk_seg_fault_code: assert property ( // RL4
        @(posedge ref_clk) disable iff (!arst_n)
        (seg_chk_req && seg_chk_done && seg_res.stack_viol)
        |=> acc_fault.code == ppc_pkg::PPC_EXC_STACK_FAULT)
        else $error("segment stack violation not reported as stack fault");

    chk_page_fault_code: assert property ( // RL5
        @(posedge ref_clk) disable iff (!arst_n)
        (page_chk_req && page_chk_done && page_viol)
        |=> acc_fault.code == ppc_pkg::PPC_EXC_PAGE_FAULT)
        else $error("page violation not reported as page fault");

    chk_priv0_gate: assert property ( // RL16
        @(posedge ref_clk) disable iff (!arst_n)
        (instr_valid && cls == ppc_pkg::PPC_CLS_PRIV0 && !is_super)
        |=> instr_fault && !instr_exec
            && instr_fault_code == ppc_pkg::PPC_EXC_GENERAL_PROTECTION_FAULT)
        else $error("level zero instruction not faulted at user level");

    chk_priv0_super: assert property ( // RL6
        @(posedge ref_clk) disable iff (!arst_n)
        (instr_valid && cls == ppc_pkg::PPC_CLS_PRIV0 && is_super) |=> instr_exec)
        else $error("level zero instruction refused at level zero");

    chk_os_ctl_gate: assert property ( // RL11
        @(posedge ref_clk) disable iff (!arst_n)
        (instr_valid && cls == ppc_pkg::PPC_CLS_OSCTL && !is_super)
        |=> instr_exec == $past(os_user_allow[os_idx]))
        else $error("os controlled instruction ignored configuration");

    chk_any_level: assert property ( // RL12
        @(posedge ref_clk) disable iff (!arst_n)
        (instr_valid && cls == ppc_pkg::PPC_CLS_ANY) |=> instr_exec && !instr_fault)
        else $error("unrestricted instruction was faulted");

    chk_seg_gp_code: assert property ( // RL4
        @(posedge ref_clk) disable iff (!arst_n)
        (seg_chk_req && seg_chk_done && seg_res.prot_viol && !seg_res.stack_viol)
        |=> acc_fault.code == ppc_pkg::PPC_EXC_GENERAL_PROTECTION_FAULT)
        else $error("segment protection violation not reported as general protection");

    chk_take_starts_seg: assert property ( // RL1
        @(posedge ref_clk) disable iff (!arst_n)
        (acc_valid && acc_ready) |=> seg_chk_req && !page_chk_req)
        else $error("accepted access did not start with the segment check");

    chk_seg_req_holds: assert property ( // RL1
        @(posedge ref_clk) disable iff (!arst_n)
        (seg_chk_req && !seg_chk_done) |=> seg_chk_req)
        else $error("segment check dropped before its answer");

    chk_page_req_holds: assert property ( // RL1
        @(posedge ref_clk) disable iff (!arst_n)
        (page_chk_req && !page_chk_done) |=> page_chk_req)
        else $error("page check dropped before its answer");

    chk_fault_blocks_mem: assert property ( // RL3
        @(posedge ref_clk) disable iff (!arst_n)
        acc_fault.valid |-> !mem_req && acc_fault.code != ppc_pkg::PPC_EXC_NONE)
        else $error("faulted access also reached memory");

    chk_verdict_onehot: assert property ( // RL16
        @(posedge ref_clk) disable iff (!arst_n)
        instr_valid |=> instr_exec != instr_fault)
        else $error("instruction verdict not exactly one of execute and fault");

    chk_verdict_idle: assert property ( // RL16
        @(posedge ref_clk) disable iff (!arst_n)
        !instr_valid |=> !instr_exec && !instr_fault)
        else $error("instruction verdict without a request");

    chk_fault_code_gp: assert property ( // RL16
        @(posedge ref_clk) disable iff (!arst_n)
        instr_fault |-> instr_fault_code == ppc_pkg::PPC_EXC_GENERAL_PROTECTION_FAULT)
        else $error("suppressed instruction not reported as general protection");

endmodule

// *** testbench/ppc_protect_check_test.sv ***
// Self-checking testbench for the privilege and protection checker
`include "ppc_map.svh"

module ppc_protect_check_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam ppc_pkg::ppc_exc_e exc_no = ppc_pkg::PPC_EXC_NONE;
    localparam ppc_pkg::ppc_exc_e exc_gpf = ppc_pkg::PPC_EXC_GENERAL_PROTECTION_FAULT;
    localparam ppc_pkg::ppc_exc_e exc_ss  = ppc_pkg::PPC_EXC_STACK_FAULT;
    localparam ppc_pkg::ppc_exc_e exc_pgf = ppc_pkg::PPC_EXC_PAGE_FAULT;

    logic                      ref_clk;
    logic                      arst_n;
    logic                      instr_valid;
    ppc_pkg::ppc_instr_s       instr;
    logic [`PPC_OS_BITS-1:0]   os_user_allow;
    logic                      instr_exec;
    logic                      instr_fault;
    ppc_pkg::ppc_exc_e         instr_fault_code;
    logic                      acc_valid;
    logic                      acc_ready;
    logic                      seg_chk_req;
    logic                      seg_chk_done;
    ppc_pkg::ppc_seg_res_s     seg_res;
    logic                      page_chk_req;
    logic                      page_chk_done;
    logic                      page_viol;
    logic                      mem_req;
    ppc_pkg::ppc_fault_s       acc_fault;
    int                        fail_count;
    int                        samples_checked;

    ppc_protect_check dut (
        .ref_clk(ref_clk), .arst_n(arst_n),
        .instr_valid(instr_valid), .instr(instr), .os_user_allow(os_user_allow),
        .instr_exec(instr_exec), .instr_fault(instr_fault),
        .instr_fault_code(instr_fault_code),
        .acc_valid(acc_valid), .acc_ready(acc_ready),
        .seg_chk_req(seg_chk_req), .seg_chk_done(seg_chk_done), .seg_res(seg_res),
        .page_chk_req(page_chk_req), .page_chk_done(page_chk_done), .page_viol(page_viol),
        .mem_req(mem_req), .acc_fault(acc_fault)
    );

    always #2.5 ref_clk = ~ref_clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic logic exp_allowed(ppc_pkg::ppc_op_e op, logic [1:0] lvl, logic [5:0] al);
        if (lvl == 2'h0) begin
            return 1'b1;
        end
        case (op)
            ppc_pkg::PPC_OP_IRQ_FLAG_CLEAR:        return al[0];
            ppc_pkg::PPC_OP_WATCH_SETUP:           return al[1];
            ppc_pkg::PPC_OP_WATCH_WAIT:            return al[2];
            ppc_pkg::PPC_OP_PERF_COUNTER_READ:     return al[3];
            ppc_pkg::PPC_OP_TIMESTAMP_READ:        return al[4];
            ppc_pkg::PPC_OP_TIMESTAMP_CPU_ID_READ: return al[5];
            ppc_pkg::PPC_OP_CONTROL_REG_MOVE, ppc_pkg::PPC_OP_DEBUG_REG_MOVE,
            ppc_pkg::PPC_OP_GLOBAL_TABLE_LOAD, ppc_pkg::PPC_OP_INTERRUPT_TABLE_LOAD,
            ppc_pkg::PPC_OP_LOCAL_TABLE_LOAD, ppc_pkg::PPC_OP_TASK_REG_LOAD,
            ppc_pkg::PPC_OP_MODEL_SPECIFIC_READ, ppc_pkg::PPC_OP_STATUS_WORD_LOAD,
            ppc_pkg::PPC_OP_CACHE_INVALIDATE, ppc_pkg::PPC_OP_TLB_ENTRY_INVALIDATE,
            ppc_pkg::PPC_OP_TAGGED_TLB_INVALIDATE, ppc_pkg::PPC_OP_GLOBAL_IRQ_FLAG_CLEAR,
            ppc_pkg::PPC_OP_TASK_SWITCHED_CLEAR, ppc_pkg::PPC_OP_HALT_INSTRUCTION,
            ppc_pkg::PPC_OP_SECURE_ATTESTED_INIT:  return 1'b0;
            default:                               return 1'b1;
        endcase
    endfunction

    // Every op at every level, back to back, so each verdict is checked while the next is taken
    task automatic instr_sweep(input logic [5:0] allow);
        logic ok;
        logic have;
        have = 1'b0;
        ok = 1'b0;
        os_user_allow = allow;
        for (int k = 0; k < 129; k++) begin
            if (have) begin
                check(instr_exec, ok, "exec");
                check(instr_fault, !ok, "fault");
                check(instr_fault_code, ok ? exc_no : exc_gpf, "fault code");
            end
            if (k < 128) begin
                instr_valid = 1'b1;
                instr.op = ppc_pkg::ppc_op_e'(k[4:0]);
                instr.current_privilege_level = k[6:5];
                ok = exp_allowed(instr.op, k[6:5], allow);
                have = 1'b1;
            end else begin
                instr_valid = 1'b0;
            end
            @(negedge ref_clk);
        end
        check({instr_exec, instr_fault}, 2'b00, "verdict idle");
    endtask

    // One access; stage results are set inverted once their done cycle ends
    task automatic access(input logic [1:0] res, input logic pv, input int sw, input int pw,
                          input logic fv, input ppc_pkg::ppc_exc_e code);
        check(acc_ready, 1'b1, "ready idle");
        acc_valid = 1'b1;
        @(negedge ref_clk);
        acc_valid = 1'b0;
        check(acc_ready, 1'b0, "ready busy");
        for (int i = 0; i <= sw; i++) begin
            check({seg_chk_req, page_chk_req, mem_req}, 3'b100, "segment wait");
            if (i < sw) begin
                @(negedge ref_clk);
            end
        end
        seg_chk_done = 1'b1;
        seg_res = res;
        @(negedge ref_clk);
        seg_chk_done = 1'b0;
        seg_res = ~res;
        check(seg_chk_req, 1'b0, "segment req drop");
        check(page_chk_req, res == 2'b00, "page req");
        if (res == 2'b00) begin
            for (int i = 0; i < pw; i++) begin
                check({page_chk_req, mem_req, acc_fault.valid}, 3'b100, "page wait");
                @(negedge ref_clk);
            end
            page_chk_done = 1'b1;
            page_viol = pv;
            @(negedge ref_clk);
            page_chk_done = 1'b0;
            page_viol = ~pv;
            check(page_chk_req, 1'b0, "page req drop");
        end
        check(mem_req, !fv, "memory request");
        check(acc_fault, {fv, code}, "access fault");
        check(acc_ready, 1'b1, "ready after");
        @(negedge ref_clk);
        check({mem_req, acc_fault.valid}, 2'b00, "outcome pulse");
    endtask

    initial begin
        ref_clk = 1'b0;
        arst_n = 1'b0;
        instr_valid = 1'b0;
        instr = '0;
        os_user_allow = '0;
        acc_valid = 1'b0;
        seg_chk_done = 1'b0;
        seg_res = 2'b11;
        page_chk_done = 1'b0;
        page_viol = 1'b1;
        fail_count = 0;
        samples_checked = 0;
        repeat (5) @(negedge ref_clk);
        check({acc_ready, seg_chk_req, page_chk_req, mem_req}, 4'h8, "reset state");
        arst_n = 1'b1;
        @(negedge ref_clk);
        instr_sweep(6'h00);
        instr_sweep(6'h3f);
        instr_sweep(6'h15);
        instr_sweep(6'h2a);
        access(2'b00, 1'b0, 0, 0, 1'b0, exc_no);
        access(2'b00, 1'b0, 3, 2, 1'b0, exc_no);
        access(2'b10, 1'b1, 0, 0, 1'b1, exc_gpf);
        access(2'b01, 1'b1, 2, 0, 1'b1, exc_ss);
        access(2'b11, 1'b0, 1, 0, 1'b1, exc_ss);
        access(2'b00, 1'b1, 0, 0, 1'b1, exc_pgf);
        access(2'b00, 1'b1, 1, 4, 1'b1, exc_pgf);
        // Stray stage answers while idle must not start or finish anything
        seg_chk_done = 1'b1;
        page_chk_done = 1'b1;
        @(negedge ref_clk);
        seg_chk_done = 1'b0;
        page_chk_done = 1'b0;
        check({seg_chk_req, page_chk_req, mem_req, acc_fault.valid}, 4'h0, "idle done");
        // Reset in mid access drops the pending stage
        acc_valid = 1'b1;
        @(negedge ref_clk);
        acc_valid = 1'b0;
        arst_n = 1'b0;
        @(negedge ref_clk);
        check({acc_ready, seg_chk_req, mem_req}, 3'b100, "mid reset");
        arst_n = 1'b1;
        @(negedge ref_clk);
        access(2'b00, 1'b0, 0, 1, 1'b0, exc_no);
        report_and_stop();
    end

    // Bounds the whole run so a hang ends in the closing report
    initial begin
        repeat (5000) @(negedge ref_clk);
        check(1'b0, 1'b1, "run limit");
        report_and_stop();
    end
endmodule
